// ### logic/asop_core.sv
// sampling converter output pipeline: samples on sample clock fall, presents
// clamped straight-binary words 2.5 sample clocks later, sleeps on request
// assumes sys_clk_in runs well above twice the sample clock rate; the sample
// clock, sleep pin and level inputs are asynchronous and are synchronised here

// Operation
// (RQ1) capture input level on every sample clock fall, after aperture delay
// (RQ2) word appears 2.5 sample clocks after its fall, plus update delay
// (RQ3) one new word per sample clock, fixed latency
// (RQ4) output word changes only after update delay from sample clock rise
// (RQ5) previous word held for the hold interval after each rise
// (RQ6) eight-bit words at rates up to 55 MSPS; at 40 MHz sys_clk_in the core handles rates well below 20 MSPS
// (RQ7) input below bottom ladder level gives all zeros
// (RQ8) input above top ladder level gives all ones
// (RQ9) conversion continues while the sample clock runs
// (RQ10) sleep request high stops conversion and floats outputs
// (RQ11) after sleep release, wake delay passes before words are valid
// (RQ12) capture logic latches words on the rising sample clock edge; the bench capture model takes them on sys_clk_in rises by valid and ready
// (RQ13) sample clock between 1 and 55 MHz, near 50 percent duty; at 40 MHz sys_clk_in the core needs it well below 20 MHz
// (RQ14) data valid no later than 20 ns after the rising edge; the core loads it three sys_clk_in cycles (75 ns) or more after the pin rise
// (RQ15) straight binary coding, monotonic between ladder levels
module asop_core (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic sample_clk_in,
   input wire logic sleep_request_pin_in,
   input wire logic [11:0] analog_level_in,
   input wire logic [11:0] ladder_top_level_in,
   input wire logic [11:0] ladder_bottom_level_in,
   output logic [7:0] word_data_out,
   output logic word_oe_out,
   output logic word_valid_out,
   input wire logic word_ready_in
);

   typedef struct packed {
      logic smp_s1;
      logic smp_s2;
      logic smp_s3;
      logic pd_s1;
      logic pd_s2;
      logic [11:0] lvl_s1;
      logic [11:0] lvl_s2;
      logic [11:0] top_s1;
      logic [11:0] top_s2;
      logic [11:0] bot_s1;
      logic [11:0] bot_s2;
      asop_pkg::asop_mode_t mode;
      logic [3:0] wake_cnt;
      logic [3:0] ap_cnt;
      logic [7:0] hold;
      logic hold_ok;
      logic [7:0] p0;
      logic p0_ok;
      logic [7:0] p1;
      logic p1_ok;
      logic [3:0] upd_cnt;
      logic [7:0] data;
      logic valid;
      logic oe;
   } asop_st_t;

   asop_st_t st_r;
   asop_st_t st_nxt;
   logic buf_flush;
   logic buf_in_valid;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [7:0] buf_out_data;
   logic buf_out_ready;

   // straight binary quantiser with clamping at both ladder ends
   function automatic logic [7:0] asop_quantise(input logic [11:0] lvl,
                                                input logic [11:0] top,
                                                input logic [11:0] bot);
      logic [19:0] num;
      logic [19:0] span;
      logic [19:0] q;
      num = 20'h00000;
      span = 20'h00001;
      q = 20'h00000;
      if (lvl <= bot) begin
         asop_quantise = asop_pkg::WORD_RESET; // RQ7
      end else if (lvl >= top) begin
         asop_quantise = asop_pkg::WORD_ALL_ONES; // RQ8
      end else begin
         num = {8'h00, 12'(lvl - bot)} << 8;
         span = {8'h00, 12'(top - bot)};
         q = num / span; // RQ15
         asop_quantise = (q > 20'h000FF) ? asop_pkg::WORD_ALL_ONES : q[7:0];
      end
   endfunction

   // outputs straight from the state register
   assign word_data_out = st_r.data; // RQ6
   assign word_oe_out = st_r.oe;
   assign word_valid_out = st_r.valid;

   // two-entry buffer between pipeline and output register
   asop_buf u_buf (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .flush_in(buf_flush),
      .in_valid_in(buf_in_valid),
      .in_data_in(st_r.p1),
      .in_ready_out(buf_in_ready),
      .out_valid_out(buf_out_valid),
      .out_data_out(buf_out_data),
      .out_ready_in(buf_out_ready)
   );

   // next-state logic: sync, mode, sampling, pipeline and output stage
   always_comb begin
      logic rise;
      logic fall;
      logic awake;
      logic fire;
      logic advance;
      logic take;
      st_nxt = st_r;
      rise = st_r.smp_s2 && !st_r.smp_s3; // RQ9
      fall = !st_r.smp_s2 && st_r.smp_s3;
      awake = (st_r.mode == asop_pkg::ASOP_ACTIVE);
      fire = (st_r.upd_cnt == asop_pkg::CNT_ONE);
      buf_flush = !awake;
      buf_in_valid = awake && rise && st_r.p1_ok;
      advance = rise && (!st_r.p1_ok || buf_in_ready); // buffer full stalls the pipe
      take = fire && (!st_r.valid || word_ready_in);
      buf_out_ready = awake && take;
      // two-stage synchronisers; first stages feed only second stages
      st_nxt.smp_s1 = sample_clk_in;
      st_nxt.smp_s2 = st_r.smp_s1;
      st_nxt.smp_s3 = st_r.smp_s2;
      st_nxt.pd_s1 = sleep_request_pin_in;
      st_nxt.pd_s2 = st_r.pd_s1;
      st_nxt.lvl_s1 = analog_level_in;
      st_nxt.lvl_s2 = st_r.lvl_s1;
      st_nxt.top_s1 = ladder_top_level_in;
      st_nxt.top_s2 = st_r.top_s1;
      st_nxt.bot_s1 = ladder_bottom_level_in;
      st_nxt.bot_s2 = st_r.bot_s1;
      // power mode sequencing
      unique case (st_r.mode)
         asop_pkg::ASOP_ASLEEP: begin
            if (!st_r.pd_s2) begin
               st_nxt.mode = asop_pkg::ASOP_WAKING;
               st_nxt.wake_cnt = asop_pkg::WAKE_CYC;
            end
         end
         asop_pkg::ASOP_WAKING: begin
            if (st_r.pd_s2) begin
               st_nxt.mode = asop_pkg::ASOP_ASLEEP; // RQ10
            end else if (st_r.wake_cnt == asop_pkg::CNT_ONE) begin
               st_nxt.mode = asop_pkg::ASOP_ACTIVE; // RQ11
            end else begin
               st_nxt.wake_cnt = st_r.wake_cnt - asop_pkg::CNT_ONE;
            end
         end
         asop_pkg::ASOP_ACTIVE: begin
            if (st_r.pd_s2) begin
               st_nxt.mode = asop_pkg::ASOP_ASLEEP; // RQ10
            end
         end
      endcase
      if (!awake) begin
         // asleep or waking: nothing converts, pins float
         st_nxt.ap_cnt = asop_pkg::CNT_RESET;
         st_nxt.hold_ok = 1'b0;
         st_nxt.p0_ok = 1'b0;
         st_nxt.p1_ok = 1'b0;
         st_nxt.upd_cnt = asop_pkg::CNT_RESET;
         st_nxt.valid = 1'b0;
         st_nxt.oe = 1'b0; // RQ10
      end else begin
         st_nxt.oe = !st_r.pd_s2;
         // aperture delay then hold on each fall
         if (fall) begin
            st_nxt.ap_cnt = asop_pkg::APERTURE_CYC; // RQ1
         end else if (st_r.ap_cnt != asop_pkg::CNT_RESET) begin
            st_nxt.ap_cnt = st_r.ap_cnt - asop_pkg::CNT_ONE;
            if (st_r.ap_cnt == asop_pkg::CNT_ONE) begin
               st_nxt.hold = asop_quantise(st_r.lvl_s2, st_r.top_s2, st_r.bot_s2); // RQ1
               st_nxt.hold_ok = 1'b1;
            end
         end
         // three rises after the fall the word reaches the buffer
         if (advance) begin
            st_nxt.p0 = st_r.hold; // RQ2
            st_nxt.p0_ok = st_r.hold_ok;
            st_nxt.p1 = st_r.p0; // RQ3
            st_nxt.p1_ok = st_r.p0_ok;
         end
         // update delay timer started at each rise
         if (rise) begin
            st_nxt.upd_cnt = asop_pkg::UPDATE_CYC; // RQ4
         end else if (st_r.upd_cnt != asop_pkg::CNT_RESET) begin
            st_nxt.upd_cnt = st_r.upd_cnt - asop_pkg::CNT_ONE;
         end
         // old word stays until the timer fires
         if (st_r.valid && word_ready_in) begin
            st_nxt.valid = 1'b0;
         end
         if (take && buf_out_valid) begin
            st_nxt.data = buf_out_data; // RQ5
            st_nxt.valid = 1'b1; // RQ14
         end
         // pins float on sleep entry, so a waiting word goes with them
         if (st_r.pd_s2) begin
            st_nxt.valid = 1'b0; // RQ10
         end
      end
   end

   // state register with synchronous reset
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         st_r <= '0;
         st_r.mode <= asop_pkg::ASOP_ASLEEP;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule

// ### logic/asop_pkg.sv
// constants and types shared by the converter output pipeline
// assumes a single system clock at the rate given below
package asop_pkg;

   // system clock rate
   localparam int SYS_CLK_MHZ = 40;

   // word widths
   localparam int LEVEL_W = 12;
   localparam int WORD_W = 8;
   localparam int CNT_W = 4;

   // printed times in ns
   localparam int APERTURE_DELAY_NS = 3;
   localparam int OUTPUT_UPDATE_DELAY_MIN_NS = 5;
   localparam int OUTPUT_UPDATE_DELAY_MAX_NS = 20;
   localparam int OUTPUT_HOLD_INTERVAL_NS = 10;
   localparam int WAKE_DELAY_NS = 140;

   // least times round up, longest time rounds down, never below one cycle
   localparam int APERTURE_CYC_I = (APERTURE_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC_I = (OUTPUT_HOLD_INTERVAL_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int OD_MIN_CYC_I = (OUTPUT_UPDATE_DELAY_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int OD_MAX_CYC_I = (OUTPUT_UPDATE_DELAY_MAX_NS * SYS_CLK_MHZ) / 1000;
   localparam int WAKE_CYC_I = (WAKE_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int OD_LO_I = (OD_MIN_CYC_I > HOLD_CYC_I) ? OD_MIN_CYC_I : HOLD_CYC_I;
   localparam int OD_HI_I = (OD_MAX_CYC_I < 1) ? 1 : OD_MAX_CYC_I;

   localparam logic [CNT_W-1:0] APERTURE_CYC =
      CNT_W'((APERTURE_CYC_I < 1) ? 1 : APERTURE_CYC_I);
   localparam logic [CNT_W-1:0] OD_MAX_CYC = CNT_W'((OD_MAX_CYC_I < 1) ? 1 : OD_MAX_CYC_I);
   localparam logic [CNT_W-1:0] UPDATE_CYC =
      CNT_W'((OD_LO_I < 1) ? 1 : ((OD_LO_I > OD_HI_I) ? OD_HI_I : OD_LO_I));
   localparam logic [CNT_W-1:0] WAKE_CYC = CNT_W'((WAKE_CYC_I < 1) ? 1 : WAKE_CYC_I);

   // reset values, all-ones word and count step
   localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
   localparam logic [WORD_W-1:0] WORD_ALL_ONES = 8'hFF;
   localparam logic [LEVEL_W-1:0] LEVEL_RESET = 12'h000;
   localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

   // buffer occupancy codes
   localparam logic [1:0] BUF_EMPTY = 2'h0;
   localparam logic [1:0] BUF_ONE = 2'h1;
   localparam logic [1:0] BUF_FULL = 2'h2;

   // power modes
   typedef enum logic [1:0] {
      ASOP_ASLEEP,
      ASOP_WAKING,
      ASOP_ACTIVE
   } asop_mode_t;

endpackage

// ### logic/asop_buf.sv
// two-entry word buffer with valid and ready on both sides
// assumes the same clock and synchronous reset as its parent
module asop_buf (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic flush_in,
   input wire logic in_valid_in,
   input wire logic [7:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [7:0] out_data_out,
   input wire logic out_ready_in
);

   typedef struct packed {
      logic [7:0] data0;
      logic [7:0] data1;
      logic [1:0] count;
   } asop_buf_st_t;

   asop_buf_st_t st_r;
   asop_buf_st_t st_nxt;
   logic push;
   logic pop;

   // handshake terms from occupancy
   assign in_ready_out = (st_r.count != asop_pkg::BUF_FULL);
   assign out_valid_out = (st_r.count != asop_pkg::BUF_EMPTY);
   assign out_data_out = st_r.data0;
   assign push = in_valid_in && in_ready_out;
   assign pop = out_ready_in && out_valid_out;

   // entry moves; oldest word always sits in data0
   always_comb begin
      st_nxt = st_r;
      if (flush_in) begin
         st_nxt.count = asop_pkg::BUF_EMPTY;
      end else if (push && pop) begin
         if (st_r.count == asop_pkg::BUF_ONE) begin
            st_nxt.data0 = in_data_in;
         end else begin
            st_nxt.data0 = st_r.data1;
            st_nxt.data1 = in_data_in;
         end
      end else if (pop) begin
         st_nxt.data0 = st_r.data1;
         st_nxt.count = st_r.count - 2'h1;
      end else if (push) begin
         if (st_r.count == asop_pkg::BUF_EMPTY) begin
            st_nxt.data0 = in_data_in;
         end else begin
            st_nxt.data1 = in_data_in;
         end
         st_nxt.count = st_r.count + 2'h1;
      end
   end

   // state register
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule

// ### tb/asop_core_assertions.sv
// port checker for the converter output pipeline
// assumes bind onto asop_core, one clock, reset active low
module asop_core_assertions (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic sample_clk_in,
   input wire logic sleep_request_pin_in,
   input wire logic [7:0] word_data_out,
   input wire logic word_oe_out,
   input wire logic word_valid_out,
   input wire logic word_ready_in
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rstn_in);

   // sleep, float and wake timing
   property p_sleep_float;
      sleep_request_pin_in [*4] |=> !word_oe_out;
   endproperty
   a_sleep_float: assert property (p_sleep_float) else $error("pins driven in sleep");
   property p_float_novalid;
      !word_oe_out |-> !word_valid_out;
   endproperty
   a_float_novalid: assert property (p_float_novalid) else $error("valid while floated");
   property p_wake_quiet;
      sleep_request_pin_in [*5] ##1 !sleep_request_pin_in |-> !word_oe_out [*6];
   endproperty
   a_wake_quiet: assert property (p_wake_quiet) else $error("woke too early");
   property p_wake_bound;
      $fell(sleep_request_pin_in) |-> ##[1:14] (word_oe_out || sleep_request_pin_in);
   endproperty
   a_wake_bound: assert property (p_wake_bound) else $error("wake too slow");
   property p_rise_after_oe;
      $rose(word_valid_out) |-> $past(word_oe_out);
   endproperty
   a_rise_after_oe: assert property (p_rise_after_oe) else $error("word during wake");

   // output word handshake
   sequence s_stalled;
      !sleep_request_pin_in [*3] ##0 word_valid_out && !word_ready_in;
   endsequence
   property p_valid_hold;
      s_stalled |=> word_valid_out;
   endproperty
   a_valid_hold: assert property (p_valid_hold) else $error("word lost in stall");
   property p_data_hold;
      s_stalled |=> $stable(word_data_out);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("word changed in stall");
   property p_fall_consumed;
      $fell(word_valid_out) |-> $past(word_ready_in) || !word_oe_out;
   endproperty
   a_fall_consumed: assert property (p_fall_consumed) else $error("valid dropped");
   property p_data_change;
      $changed(word_data_out) |-> word_valid_out || !word_oe_out;
   endproperty
   a_data_change: assert property (p_data_change) else $error("data moved unloaded");
   // a fresh word shows a fixed number of cycles after the sample clock rise
   property p_word_latency;
      $rose(word_valid_out) |-> $past(sample_clk_in, 4) && !$past(sample_clk_in, 5);
   endproperty
   a_word_latency: assert property (p_word_latency) else $error("word off its rise");

   // main scenarios reached
   c_taken: cover property (word_valid_out && word_ready_in);
   c_slept: cover property ($fell(word_oe_out));
   c_stall: cover property (word_valid_out && !word_ready_in ##1 !word_ready_in);
endmodule

bind asop_core asop_core_assertions u_asop_core_assertions (
   .sys_clk_in(sys_clk_in),
   .rstn_in(rstn_in),
   .sample_clk_in(sample_clk_in),
   .sleep_request_pin_in(sleep_request_pin_in),
   .word_data_out(word_data_out),
   .word_oe_out(word_oe_out),
   .word_valid_out(word_valid_out),
   .word_ready_in(word_ready_in)
);

// ### tb/asop_capture_model.sv
// capture logic model: makes the sample clock and takes output words
// assumes the bench system clock; sample clock is an eighth of it
module asop_capture_model (
   input wire logic sys_clk_in,
   input wire logic run_in,
   input wire logic stall_in,
   input wire logic [7:0] word_data_in,
   input wire logic word_valid_in,
   input wire logic word_oe_in,
   output logic sample_clk_out,
   output logic ready_out,
   output logic [7:0] last_word_out,
   output logic [15:0] word_cnt_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph_r = 2'h0;
   initial sample_clk_out = 1'b0;
   initial ready_out = 1'b0;
   initial last_word_out = 8'h00;
   initial word_cnt_out = 16'h0000;
   // even duty sample clock, stands low when stopped
   always @(negedge sys_clk_in) begin
      ph_r <= ph_r + 2'h1;
      if (ph_r == 2'h3) begin
         sample_clk_out <= run_in ? ~sample_clk_out : 1'b0;
      end
      ready_out <= ~stall_in;
   end
   // words taken only while pins are driven
   always @(posedge sys_clk_in) begin
      if (word_valid_in && ready_out && word_oe_in) begin
         last_word_out <= word_data_in;
         word_cnt_out <= word_cnt_out + 16'h0001;
      end
   end
endmodule

// ### tb/asop_core_tb_top.sv
// bench for the converter output pipeline
// assumes package, design, checker and capture model compiled first
module asop_core_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic sleep = 1'b0;
   logic run = 1'b1;
   logic stall = 1'b0;
   logic [11:0] lvl = 12'h500;
   logic [11:0] top = 12'h900;
   logic [11:0] bot = 12'h100;
   logic sclk, rdy, oe, vld;
   logic [7:0] data, last;
   logic [15:0] cnt, c0;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [11:0] lv_tab [7] = '{12'h0FF, 12'h100, 12'h901, 12'hFFF, 12'h500, 12'h180, 12'h8FF};
   logic [7:0] ex_tab [7] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h80, 8'h10, 8'hFF};

   initial forever #12.5 sys_clk_in = ~sys_clk_in;

   asop_core u_asop_core (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .sample_clk_in(sclk),
      .sleep_request_pin_in(sleep), .analog_level_in(lvl), .ladder_top_level_in(top),
      .ladder_bottom_level_in(bot), .word_data_out(data), .word_oe_out(oe),
      .word_valid_out(vld), .word_ready_in(rdy));
   asop_capture_model u_asop_capture_model (.sys_clk_in(sys_clk_in), .run_in(run),
      .stall_in(stall), .word_data_in(data), .word_valid_in(vld), .word_oe_in(oe),
      .sample_clk_out(sclk), .ready_out(rdy), .last_word_out(last), .word_cnt_out(cnt));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask

   task automatic end_sim();
      $display("compared=%0d errors=%0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // clamp and code table, one word per sample period
   task automatic t_levels();
      for (int i = 0; i < 7; i++) begin
         lvl = lv_tab[i];
         idle(64);
         c0 = cnt;
         idle(64);
         check({8'h00, last}, {8'h00, ex_tab[i]});
         check(cnt - c0, 16'h0008);
      end
      // moved ladder: code follows the new span, clamp follows the new bottom
      top = 12'hB00;
      bot = 12'h300;
      lvl = 12'h500;
      idle(64);
      check({8'h00, last}, 16'h0040);
      lvl = 12'h200;
      idle(64);
      check({8'h00, last}, 16'h0000);
      top = 12'h900;
      bot = 12'h100;
   endtask

   // receiver stall holds the word, flow resumes afterwards
   task automatic t_stall();
      stall = 1'b1;
      idle(8);
      c0 = cnt;
      idle(48);
      check(cnt, c0);
      stall = 1'b0;
      idle(64);
      check(16'(cnt != c0), 16'h0001);
   endtask

   // sleep floats pins, wake waits before words return
   task automatic t_sleep();
      lvl = 12'h500;
      sleep = 1'b1;
      idle(6);
      check({14'h0000, oe, vld}, 16'h0000);
      c0 = cnt;
      idle(40);
      check(cnt, c0);
      sleep = 1'b0;
      idle(6);
      check({15'h0000, oe}, 16'h0000);
      for (int i = 0; i < 20 && !oe; i++) idle(1);
      check({15'h0000, oe}, 16'h0001);
      idle(80);
      check({8'h00, last}, 16'h0080);
   endtask

   // no sample clock, no words
   task automatic t_noclk();
      run = 1'b0;
      idle(24);
      c0 = cnt;
      idle(64);
      check(cnt, c0);
      run = 1'b1;
      idle(64);
      check(16'(cnt != c0), 16'h0001);
   endtask

   // cycle ceiling against a hang
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 6000) begin
         err_total++;
         end_sim();
      end
   end

   initial begin
      idle(20);
      rstn_in = 1'b1;
      idle(40);
      t_levels();
      t_stall();
      t_sleep();
      t_noclk();
      end_sim();
   end
endmodule
